// ### verilog/sdram_pwr_pkg.sv
// constants and types shared by the refresh and power-state logic
package sdram_pwr_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 40;
  localparam int REFRESH_PERIOD_MS      = 64;
  localparam int REFRESH_CYCLE_TIME_NS  = 70;
  localparam int SELF_REFRESH_EXIT_CLKS = 2;
  localparam int ROW_BITS               = 12;
  // least time, rounded up to whole cycles
  localparam int REFRESH_CYCLE_CLKS =
    (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // whole refresh period in cycles
  localparam int REFRESH_PERIOD_CLKS =
    REFRESH_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  // distributed interval, rounded down
  localparam int REFRESH_INTERVAL_CLKS = REFRESH_PERIOD_CLKS >> ROW_BITS;

  // ----------------------------------------------------------------
  // command encoding {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_NOP     = 4'h7;
  localparam logic [3:0] CMD_NOP_MSK = 4'h8;

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_SUSPEND,
    ST_PD_PRE,
    ST_PD_ACT,
    ST_SELF,
    ST_SELF_EXIT
  } pwr_state_t;

endpackage : sdram_pwr_pkg

// ### verilog/self_refresh_timer.sv
// internal timing source that paces refresh cycles in self refresh
`timescale 1ns/100ps
`default_nettype none
module self_refresh_timer #(
  parameter int INTERVAL = sdram_pwr_pkg::REFRESH_INTERVAL_CLKS,
  parameter int CW       = $clog2(INTERVAL + 1)
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  // control
  input  wire logic run_i,
  output logic      tick_o
);
  import sdram_pwr_pkg::*;

  localparam logic [CW-1:0] LAST = CW'(INTERVAL - 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          tick_ff;
  logic          nxt_tick;

  // free count while running, restart when stopped
  always_comb begin
    nxt_cnt  = '0;
    nxt_tick = 1'b0;
    if (run_i) begin
      if (cnt_ff == LAST) begin
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + CW'(1);
      end
    end
  end

  // state registers
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff;

endmodule : self_refresh_timer
`default_nettype wire

// ### verilog/sdram_refresh_power_control.sv
// refresh, self refresh, power-down and clock suspend state logic
// Notes on behaviour
// - refresh row comes from internal counter
// - self refresh ignores all but clock-enable
// - low enable with nop, idle enters power-down
// - banks idle gives precharge, else active power-down
// - power-down disables buffers and refresh
// - nop with enable high ends power-down
// - low enable during burst enters clock suspend
// - each low sample skips next internal edge
// - suspended burst holds data and counters
// - enable high resumes on following edge
`timescale 1ns/100ps
`default_nettype none
module sdram_refresh_power_control #(
  parameter int RFC_CLKS = sdram_pwr_pkg::REFRESH_CYCLE_CLKS,
  parameter int XSR_CLKS = sdram_pwr_pkg::SELF_REFRESH_EXIT_CLKS,
  parameter int INTERVAL = sdram_pwr_pkg::REFRESH_INTERVAL_CLKS,
  parameter int PD_LIMIT = sdram_pwr_pkg::REFRESH_PERIOD_CLKS,
  parameter int RB       = sdram_pwr_pkg::ROW_BITS
) (
  // clock and reset
  input  wire logic          ref_clk_i,
  input  wire logic          nrst_i,
  // command pins from the controller
  input  wire logic          cke_i,
  input  wire logic          cs_n_i,
  input  wire logic          ras_n_i,
  input  wire logic          cas_n_i,
  input  wire logic          we_n_i,
  // bank and burst status from the core
  input  wire logic [3:0]    bank_open_i,
  input  wire logic          burst_active_i,
  // internal clocking and refresh
  output logic               int_clk_en_o,
  output logic               burst_hold_o,
  output logic               refresh_start_o,
  output logic               refresh_busy_o,
  output logic [RB-1:0]      refresh_row_o,
  output logic               addr_ignore_o,
  // power status
  output logic               buf_en_o,
  output logic               self_refresh_o,
  output logic               pd_precharge_o,
  output logic               pd_active_o,
  output logic               suspend_o,
  output logic               pd_overstay_o
);
  import sdram_pwr_pkg::*;

  localparam int RCW = $clog2(RFC_CLKS + XSR_CLKS + 1);
  localparam int PCW = $clog2(PD_LIMIT + 1);
  localparam logic [RCW-1:0] RFC_LOAD = RCW'(RFC_CLKS);
  localparam logic [RCW-1:0] XSR_LOAD = RCW'(XSR_CLKS);
  localparam logic [PCW-1:0] PD_MAX   = PCW'(PD_LIMIT);

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [3:0] cmd;
  logic       cke_ff;
  logic       nxt_cke;
  logic       live;
  logic       is_ref;
  logic       is_nop;
  logic       tick;

  assign cmd    = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  // an internal edge is live only if enable was high one edge earlier
  assign live   = cke_ff;
  assign is_ref = live && (cmd == CMD_REFRESH);
  // inhibit (cs_n high) or nop
  assign is_nop = cs_n_i || (cmd == CMD_NOP);
  assign nxt_cke = cke_i;

  // ----------------------------------------------------------------
  // state, refresh timers and row counter
  // ----------------------------------------------------------------
  pwr_state_t      state_ff;
  pwr_state_t      nxt_state;
  logic [RCW-1:0]  busy_ff;
  logic [RCW-1:0]  nxt_busy;
  logic [RCW-1:0]  exit_ff;
  logic [RCW-1:0]  nxt_exit;
  logic [RB-1:0]   row_ff;
  logic [RB-1:0]   nxt_row;
  logic [PCW-1:0]  pd_ff;
  logic [PCW-1:0]  nxt_pd;
  logic            over_ff;
  logic            nxt_over;
  logic            start;
  logic            in_pd;

  assign in_pd = (state_ff == ST_PD_PRE) || (state_ff == ST_PD_ACT);

  // refresh starts on a live command or an internal tick
  always_comb begin
    start = 1'b0;
    if (busy_ff == '0) begin
      if (state_ff == ST_NORMAL && is_ref) begin
        start = 1'b1;
      end else if (state_ff == ST_SELF && tick) begin
        start = 1'b1;
      end
    end
  end

  // next power state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_NORMAL: begin
        if (is_ref && !cke_i) begin
          nxt_state = ST_SELF;
        end else if (live && !cke_i && is_nop && !burst_active_i &&
                     busy_ff == '0) begin
          nxt_state = (bank_open_i == 4'h0) ? ST_PD_PRE : ST_PD_ACT;
        end else if (!cke_i && burst_active_i) begin
          nxt_state = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (cke_i) begin
          nxt_state = ST_NORMAL;
        end
      end
      ST_PD_PRE, ST_PD_ACT: begin
        if (cke_i && is_nop) begin
          nxt_state = ST_NORMAL;
        end
      end
      ST_SELF: begin
        // only the enable pin is looked at here
        if (cke_i) begin
          nxt_state = ST_SELF_EXIT;
        end
      end
      ST_SELF_EXIT: begin
        // leave as the exit count runs out and no refresh is running
        if (exit_ff <= RCW'(1) && busy_ff == '0) begin
          nxt_state = ST_NORMAL;
        end
      end
      default: begin
        nxt_state = ST_NORMAL;
      end
    endcase
  end

  // timers, row counter and overstay watch
  always_comb begin
    nxt_busy = (busy_ff != '0) ? busy_ff - RCW'(1) : busy_ff;
    nxt_exit = (exit_ff != '0) ? exit_ff - RCW'(1) : exit_ff;
    nxt_row  = row_ff;
    nxt_pd   = '0;
    nxt_over = over_ff;
    if (start) begin
      nxt_busy = RFC_LOAD;
      nxt_row  = row_ff + RB'(1);
    end
    if (state_ff == ST_SELF && cke_i) begin
      nxt_exit = XSR_LOAD;
    end
    if (in_pd) begin
      nxt_pd = (pd_ff == PD_MAX) ? pd_ff : pd_ff + PCW'(1);
      if (pd_ff == PD_MAX) begin
        nxt_over = 1'b1;
      end
    end else if (state_ff == ST_NORMAL) begin
      nxt_over = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state_ff <= ST_NORMAL;
      cke_ff   <= 1'b0;
      busy_ff  <= '0;
      exit_ff  <= '0;
      row_ff   <= '0;
      pd_ff    <= '0;
      over_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cke_ff   <= nxt_cke;
      busy_ff  <= nxt_busy;
      exit_ff  <= nxt_exit;
      row_ff   <= nxt_row;
      pd_ff    <= nxt_pd;
      over_ff  <= nxt_over;
    end
  end

  // internal refresh pacing
  self_refresh_timer #(
    .INTERVAL (INTERVAL)
  ) u_timer (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .run_i     (state_ff == ST_SELF),
    .tick_o    (tick)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign int_clk_en_o    = cke_ff;
  assign burst_hold_o    = !cke_ff;
  assign refresh_start_o = start;
  assign refresh_busy_o  = busy_ff != '0;
  assign refresh_row_o   = row_ff;
  assign addr_ignore_o   = start || (state_ff == ST_SELF);
  assign buf_en_o        = !in_pd && (state_ff != ST_SELF);
  assign self_refresh_o  = state_ff == ST_SELF;
  assign pd_precharge_o  = state_ff == ST_PD_PRE;
  assign pd_active_o     = state_ff == ST_PD_ACT;
  assign suspend_o       = state_ff == ST_SUSPEND;
  assign pd_overstay_o   = over_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_self_cmd;
    state_ff == ST_NORMAL && is_ref && !cke_i;
  endsequence
  sequence s_pd_cmd;
    state_ff == ST_NORMAL && live && !cke_i && is_nop &&
      !burst_active_i && busy_ff == '0 && !is_ref;
  endsequence
  sequence s_self_leave;
    state_ff == ST_SELF && cke_i;
  endsequence

  property p_row_step;
    start |=> row_ff == $past(row_ff) + RB'(1);
  endproperty
  a_row_step: assert property (p_row_step)
    else $error("row counter did not step on refresh");

  property p_self_enter;
    s_self_cmd |=> self_refresh_o && !buf_en_o;
  endproperty
  a_self_enter: assert property (p_self_enter)
    else $error("self refresh not entered");

  property p_self_stay;
    self_refresh_o && !cke_i |=> self_refresh_o;
  endproperty
  a_self_stay: assert property (p_self_stay)
    else $error("self refresh left while enable low");

  property p_pd_enter;
    s_pd_cmd |=> ($past(bank_open_i) == 4'h0) ? pd_precharge_o : pd_active_o;
  endproperty
  a_pd_enter: assert property (p_pd_enter)
    else $error("power-down kind or entry wrong");

  property p_pd_kind;
    s_pd_cmd ##1 1'b1 |-> pd_precharge_o == ($past(bank_open_i) == 4'h0);
  endproperty
  a_pd_kind: assert property (p_pd_kind)
    else $error("power-down kind mismatches bank state");

  property p_pd_quiet;
    (pd_precharge_o || pd_active_o) |-> !buf_en_o && !start;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("activity in power-down");

  property p_pd_exit;
    (pd_precharge_o || pd_active_o) && cke_i && is_nop |=> state_ff == ST_NORMAL;
  endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("power-down not left");

  property p_suspend;
    state_ff == ST_NORMAL && !cke_i && burst_active_i && !is_ref
      |=> suspend_o;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("clock suspend not entered");

  property p_skip;
    !cke_i |=> !int_clk_en_o && burst_hold_o;
  endproperty
  a_skip: assert property (p_skip)
    else $error("internal edge not skipped");

  property p_hold_row;
    burst_hold_o && state_ff == ST_NORMAL |-> !start;
  endproperty
  a_hold_row: assert property (p_hold_row)
    else $error("command acted on a skipped edge");

  property p_resume;
    suspend_o && cke_i |=> int_clk_en_o && state_ff == ST_NORMAL;
  endproperty
  a_resume: assert property (p_resume)
    else $error("suspend not resumed");

  property p_self_exit;
    s_self_leave |=> state_ff == ST_SELF_EXIT [*2] ##[1:20]
      state_ff == ST_NORMAL;
  endproperty
  a_self_exit: assert property (p_self_exit)
    else $error("self refresh exit timing wrong");

  property p_addr_ignore;
    start |-> addr_ignore_o;
  endproperty
  a_addr_ignore: assert property (p_addr_ignore)
    else $error("address not ignored during refresh");

endmodule : sdram_refresh_power_control
`default_nettype wire

// ### dv/sdram_ctrl_model.sv
// command-side model of the external memory controller
`timescale 1ns/100ps
`default_nettype none
module sdram_ctrl_model (
  // clock
  input  wire logic       ref_clk_i,
  // command pins toward the device
  output logic            cke_o,
  output logic [3:0]      cmd_o
);
  import sdram_pwr_pkg::*;

  // ----------------------------------------------------------------
  // command issue
  // ----------------------------------------------------------------
  // idle with clock enabled so the second edge out of reset sees a live device
  initial begin
    cke_o = 1'b1;
    cmd_o = CMD_NOP;
  end

  // one command per rising edge, held for the whole cycle
  task automatic send(input logic ck, input logic [3:0] c);
    @(posedge ref_clk_i);
    cke_o <= ck;
    cmd_o <= c;
  endtask : send

endmodule : sdram_ctrl_model
`default_nettype wire

// ### dv/sdram_refresh_power_control_bench.sv
// self-checking bench for the refresh and power-state logic
`timescale 1ns/100ps
`default_nettype none
module sdram_refresh_power_control_bench;
  import sdram_pwr_pkg::*;

  // ----------------------------------------------------------------
  // set-up
  // ----------------------------------------------------------------
  localparam int TICK   = 8;
  localparam int PD_LIM = 50;
  logic        ref_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic [3:0]  bank_open = 4'h0;
  logic        burst_active = 1'b0;
  logic [3:0]  want_banks = 4'h0;
  logic        want_burst = 1'b0;
  logic        cke;
  logic [3:0]  cmd;
  logic        int_clk_en, burst_hold, rf_start, rf_busy, addr_ign;
  logic        buf_en, self_rf, pd_pre, pd_act, susp, overstay;
  logic [11:0] rf_row;
  logic [11:0] erow = 12'h000;
  int          err_count = 0;
  int          cmp_count = 0;

  // 25 MHz system clock
  always #20 ref_clk = ~ref_clk;

  sdram_ctrl_model ctl (
    .ref_clk_i (ref_clk),
    .cke_o     (cke),
    .cmd_o     (cmd)
  );

  sdram_refresh_power_control #(
    .INTERVAL (TICK),
    .PD_LIMIT (PD_LIM)
  ) uut (
    .ref_clk_i       (ref_clk),
    .nrst_i          (nrst),
    .cke_i           (cke),
    .cs_n_i          (cmd[3]),
    .ras_n_i         (cmd[2]),
    .cas_n_i         (cmd[1]),
    .we_n_i          (cmd[0]),
    .bank_open_i     (bank_open),
    .burst_active_i  (burst_active),
    .int_clk_en_o    (int_clk_en),
    .burst_hold_o    (burst_hold),
    .refresh_start_o (rf_start),
    .refresh_busy_o  (rf_busy),
    .refresh_row_o   (rf_row),
    .addr_ignore_o   (addr_ign),
    .buf_en_o        (buf_en),
    .self_refresh_o  (self_rf),
    .pd_precharge_o  (pd_pre),
    .pd_active_o     (pd_act),
    .suspend_o       (susp),
    .pd_overstay_o   (overstay)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // present one command at a rising edge, look at the falling edge
  task automatic step(input logic ck, input logic [3:0] c);
    ctl.send(ck, c);
    bank_open    <= want_banks;
    burst_active <= want_burst;
    @(negedge ref_clk);
  endtask : step

  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_row(input logic [11:0] e);
    cmp_count++;
    if (rf_row !== e) begin
      err_count++;
      $display("wrong value row expected %h seen %h", e, rf_row);
    end
  endtask : chk_row

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    chk_bit("clk_en", 1'b0, int_clk_en);
    chk_bit("buf_en", 1'b1, buf_en);
    chk_row(12'h000);
    step(1'b1, CMD_NOP);
    step(1'b1, CMD_NOP);
    chk_bit("clk_en", 1'b1, int_clk_en);
    chk_bit("hold", 1'b0, burst_hold);
    $display("test reset done");
  endtask : t_reset

  // banks stay closed before every refresh
  task automatic t_auto_refresh;
    step(1'b1, CMD_REFRESH);
    chk_bit("start", 1'b1, rf_start);
    chk_bit("addr_ign", 1'b1, addr_ign);
    step(1'b1, CMD_NOP);
    chk_bit("start", 1'b0, rf_start);
    chk_bit("busy", 1'b1, rf_busy);
    chk_row(erow + 12'h001);
    step(1'b1, CMD_NOP);
    chk_bit("busy", 1'b1, rf_busy);
    step(1'b1, CMD_NOP);
    chk_bit("busy", 1'b0, rf_busy);
    step(1'b1, CMD_REFRESH);
    chk_bit("start", 1'b1, rf_start);
    step(1'b1, CMD_NOP);
    chk_row(erow + 12'h002);
    erow = erow + 12'h002;
    repeat (2) step(1'b1, CMD_NOP);
    // distributed pacing: next refresh one interval plus one cycle later
    repeat (TICK - 3) step(1'b1, CMD_NOP);
    step(1'b1, CMD_REFRESH);
    chk_bit("start", 1'b1, rf_start);
    step(1'b1, CMD_NOP);
    chk_row(erow + 12'h001);
    erow = erow + 12'h001;
    repeat (2) step(1'b1, CMD_NOP);
    $display("test auto_refresh done");
  endtask : t_auto_refresh

  task automatic t_self_refresh;
    int ticks;
    int n;
    ticks = 0;
    step(1'b0, CMD_REFRESH);
    chk_bit("start", 1'b1, rf_start);
    // refresh pattern held on pins must have no effect
    step(1'b0, CMD_REFRESH);
    chk_bit("self", 1'b1, self_rf);
    chk_bit("buf_en", 1'b0, buf_en);
    chk_bit("addr_ign", 1'b1, addr_ign);
    chk_row(erow + 12'h001);
    // hold well past the least stay
    repeat (2 * TICK + 2) begin
      step(1'b0, CMD_REFRESH);
      if (rf_start === 1'b1) ticks++;
    end
    chk_bit("ticks", 1'b1, ticks == 2);
    step(1'b0, CMD_NOP);
    chk_row(erow + 12'h003);
    erow = erow + 12'h003;
    // clock keeps running, then enable rises
    step(1'b1, CMD_NOP);
    n = 0;
    while (self_rf === 1'b1 && n < 10) begin
      step(1'b1, CMD_NOP);
      n++;
    end
    if (n == 10) begin
      err_count++;
      end_of_test();
    end
    chk_bit("self", 1'b0, self_rf);
    chk_bit("buf_en", 1'b1, buf_en);
    // exit window: only nop until it has run out
    repeat (SELF_REFRESH_EXIT_CLKS - 1) step(1'b1, CMD_NOP);
    step(1'b1, CMD_REFRESH);
    chk_bit("start", 1'b1, rf_start);
    erow = erow + 12'h001;
    repeat (3) step(1'b1, CMD_NOP);
    $display("test self_refresh done");
  endtask : t_self_refresh

  task automatic t_power_down(input logic [3:0] banks);
    want_banks = banks;
    step(1'b1, CMD_NOP);
    step(1'b0, CMD_NOP);
    step(1'b0, CMD_REFRESH);
    chk_bit("pd_pre", banks == 4'h0, pd_pre);
    chk_bit("pd_act", banks != 4'h0, pd_act);
    chk_bit("buf_en", 1'b0, buf_en);
    chk_bit("start", 1'b0, rf_start);
    repeat (PD_LIM - 10) step(1'b0, CMD_NOP);
    chk_bit("overstay", 1'b0, overstay);
    repeat (12) step(1'b0, CMD_NOP);
    chk_bit("overstay", 1'b1, overstay);
    chk_row(erow);
    step(1'b1, CMD_NOP);
    step(1'b1, CMD_NOP);
    chk_bit("pd_pre", 1'b0, pd_pre);
    chk_bit("pd_act", 1'b0, pd_act);
    chk_bit("buf_en", 1'b1, buf_en);
    step(1'b1, CMD_NOP);
    chk_bit("overstay", 1'b0, overstay);
    want_banks = 4'h0;
    step(1'b1, CMD_NOP);
    $display("test power_down done");
  endtask : t_power_down

  task automatic t_suspend;
    want_burst = 1'b1;
    step(1'b1, CMD_NOP);
    step(1'b0, CMD_NOP);
    step(1'b0, CMD_REFRESH);
    chk_bit("susp", 1'b1, susp);
    chk_bit("pd_pre", 1'b0, pd_pre);
    chk_bit("clk_en", 1'b0, int_clk_en);
    chk_bit("start", 1'b0, rf_start);
    chk_bit("hold", 1'b1, burst_hold);
    step(1'b1, CMD_NOP);
    chk_bit("susp", 1'b1, susp);
    step(1'b1, CMD_NOP);
    chk_bit("susp", 1'b0, susp);
    chk_bit("clk_en", 1'b1, int_clk_en);
    chk_bit("hold", 1'b0, burst_hold);
    want_burst = 1'b0;
    step(1'b1, CMD_NOP);
    chk_row(erow);
    $display("test suspend done");
  endtask : t_suspend

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    t_reset();
    t_auto_refresh();
    t_self_refresh();
    t_power_down(4'h0);
    t_power_down(4'h2);
    t_suspend();
    end_of_test();
  end

endmodule : sdram_refresh_power_control_bench
`default_nettype wire
